// file: core/upcbc_pkg.sv
// Package with offsets, bit positions, reset values and carrier types of the common block control.
package upcbc_pkg;
    localparam logic [11:0] UPCBC_OFF_TEST_CTRL = 12'h000;
    localparam int          UPCBC_ADDR_W        = 12;

    localparam int UPCBC_B_CLK_GATE_OFF  = 31;
    localparam int UPCBC_B_TEST_PATH_SEL = 24;
    localparam int UPCBC_B_XTAL_GAIN     = 23;
    localparam int UPCBC_B_REF_FREQ      = 19;
    localparam int UPCBC_B_CORE_READY    = 18;
    localparam int UPCBC_B_FAST_START    = 17;
    localparam int UPCBC_B_PLL_EN        = 16;
    localparam int UPCBC_B_COMMON_PD_N   = 15;
    localparam int UPCBC_B_XTAL_PD_N     = 14;
    localparam int UPCBC_B_CLK_USABLE    = 12;
    localparam int UPCBC_B_AFE_TIM_DIS   = 9;
    localparam int UPCBC_B_GATE_BYPASS   = 0;

    localparam logic [31:0] UPCBC_WR_MASK = 32'h8183_c201;
    localparam logic [31:0] UPCBC_RST_VAL = 32'h0001_0000;

    typedef struct packed {
        logic clk_gate_off;
        logic common_test_path_select;
        logic crystal_drive_gain_select;
        logic pll_reference_frequency_select;
        logic pll_fast_start_lowpower_enable;
        logic usb_pll_enable;
        logic common_power_down_n;
        logic crystal_power_down_n;
        logic frontend_ready_timer_disable;
        logic chip_clock_gating_bypass;
    } upcbc_ctrl_t;

    typedef struct packed {
        logic eeprom_present;
        logic eeprom_fast_start_hs;
        logic eeprom_fast_start_fs;
        logic otp_present;
        logic otp_fast_start;
    } upcbc_image_t;
endpackage

// file: core/upcbc_top.sv
// Common block control register of the USB PHY with an APB slave port.
//
// The APB register port was left to the implementer.
module upcbc_top
    import upcbc_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     usb_bus_reset,
    input  wire logic                     lite_reset,
    input  wire logic                     high_speed,
    input  wire upcbc_pkg::upcbc_image_t  image,
    input  wire logic                     core_supply_ready_raw,
    input  wire logic                     hv_por_active,
    input  wire logic                     pll_locked,
    output upcbc_pkg::upcbc_ctrl_t        ctrl,
    output logic                          common_clk_en,
    output logic                          common_test_mode
);
    import upcbc_pkg::*;

    logic [31:0] reg_r;
    logic [31:0] reg_nxt;
    logic [1:0]  core_sync_r;
    logic [1:0]  hvpor_sync_r;
    logic [1:0]  lock_sync_r;
    logic [1:0]  busrst_sync_r;
    logic [1:0]  lite_sync_r;
    logic [1:0]  hs_sync_r;
    logic [1:0]  init_cnt_r;
    logic        rst_req_d_r;
    logic        ready_r;
    logic        usable_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;

    wire         setup_ph   = psel & ~penable;
    wire         access_ph  = psel & penable;
    wire         hit        = (paddr == UPCBC_OFF_TEST_CTRL);
    wire         wr_hit     = setup_ph & pwrite & hit;
    wire         rst_req    = busrst_sync_r[1] | lite_sync_r[1];
    // The first load waits until the link speed has passed its synchroniser.
    wire         init_load  = (init_cnt_r == 2'h2);
    wire         reload     = (rst_req & ~rst_req_d_r) | init_load;
    // Image selection: EEPROM flag by link speed, then OTP, else zero.
    wire         eeprom_fs_bit = hs_sync_r[1] ? image.eeprom_fast_start_hs
                                               : image.eeprom_fast_start_fs;
    wire         image_fast = image.eeprom_present ? eeprom_fs_bit :
                              image.otp_present    ? image.otp_fast_start : 1'b0;
    wire         core_ok    = core_sync_r[1] & ~hvpor_sync_r[1];
    wire [31:0]  byte_mask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [31:0]  wmask      = UPCBC_WR_MASK & byte_mask;
    wire [31:0]  wr_val     = (reg_r & ~wmask) | (pwdata & wmask);
    wire [31:0]  rd_val     = (reg_r & UPCBC_WR_MASK)
                            | ({31'h0, ready_r} << UPCBC_B_CORE_READY)
                            | ({31'h0, usable_r} << UPCBC_B_CLK_USABLE);

    always_comb begin
        reg_nxt = wr_hit ? wr_val : reg_r;
        if (reload) begin
            reg_nxt[UPCBC_B_FAST_START] = image_fast;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_sync_r   <= 2'h0;
            hvpor_sync_r  <= 2'h3;
            lock_sync_r   <= 2'h0;
            busrst_sync_r <= 2'h0;
            lite_sync_r   <= 2'h0;
            hs_sync_r     <= 2'h0;
        end else begin
            core_sync_r   <= {core_sync_r[0], core_supply_ready_raw};
            hvpor_sync_r  <= {hvpor_sync_r[0], hv_por_active};
            lock_sync_r   <= {lock_sync_r[0], pll_locked};
            busrst_sync_r <= {busrst_sync_r[0], usb_bus_reset};
            lite_sync_r   <= {lite_sync_r[0], lite_reset};
            hs_sync_r     <= {hs_sync_r[0], high_speed};
        end
    end

    // Register reset holds PLL enabled and every other stored bit clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_r       <= UPCBC_RST_VAL;
            init_cnt_r  <= 2'h0;
            rst_req_d_r <= 1'b0;
            ready_r     <= 1'b0;
            usable_r    <= 1'b0;
        end else begin
            reg_r       <= reg_nxt;
            init_cnt_r  <= (init_cnt_r == 2'h3) ? init_cnt_r : init_cnt_r + 2'h1;
            rst_req_d_r <= rst_req;
            ready_r     <= core_ok;
            usable_r    <= lock_sync_r[1] & reg_r[UPCBC_B_PLL_EN]
                         & reg_r[UPCBC_B_COMMON_PD_N];
        end
    end

    // Zero-wait APB slave: answers in the access phase entered after setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setup_ph;
            pslverr_r <= setup_ph & ~hit;
            prdata_r  <= (setup_ph & ~pwrite & hit) ? rd_val : 32'h0;
        end
    end

    upcbc_ctrl_t ctrl_r;
    logic        clk_en_r;
    logic        test_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= '0;
            clk_en_r <= 1'b0;
            test_r   <= 1'b0;
        end else begin
            ctrl_r.clk_gate_off                   <= reg_r[UPCBC_B_CLK_GATE_OFF];
            ctrl_r.common_test_path_select        <= reg_r[UPCBC_B_TEST_PATH_SEL];
            ctrl_r.crystal_drive_gain_select      <= reg_r[UPCBC_B_XTAL_GAIN];
            ctrl_r.pll_reference_frequency_select <= reg_r[UPCBC_B_REF_FREQ];
            ctrl_r.pll_fast_start_lowpower_enable <= reg_r[UPCBC_B_FAST_START];
            // Common power-down overrides the PLL enable.
            ctrl_r.usb_pll_enable <= reg_r[UPCBC_B_PLL_EN]
                                   & reg_r[UPCBC_B_COMMON_PD_N];
            ctrl_r.common_power_down_n            <= reg_r[UPCBC_B_COMMON_PD_N];
            ctrl_r.crystal_power_down_n           <= reg_r[UPCBC_B_XTAL_PD_N];
            ctrl_r.frontend_ready_timer_disable   <= reg_r[UPCBC_B_AFE_TIM_DIS];
            ctrl_r.chip_clock_gating_bypass       <= reg_r[UPCBC_B_GATE_BYPASS];
            // Bypass keeps the clock running even when gate-off is set.
            clk_en_r <= ~reg_r[UPCBC_B_CLK_GATE_OFF] | reg_r[UPCBC_B_GATE_BYPASS];
            test_r   <= reg_r[UPCBC_B_TEST_PATH_SEL];
        end
    end

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign ctrl             = ctrl_r;
    assign common_clk_en    = clk_en_r;
    assign common_test_mode = test_r;
endmodule

// file: test/tb_usb_phy_common_block_control.sv
// Self-checking testbench of the common block control register.
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_usb_phy_common_block_control;
    timeunit 1ns;
    timeprecision 1ps;
    import upcbc_pkg::*;
    logic pclk = 0, presetn, psel, penable, pwrite, pready, pslverr, usb_bus_reset, lite_reset;
    logic high_speed, core_supply_ready_raw, hv_por_active, pll_locked;
    logic common_clk_en, common_test_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, m, d;
    logic [3:0] pstrb;
    logic er;
    upcbc_image_t image;
    upcbc_ctrl_t ctrl;
    int n_errors = 0, total_checks = 0;
    upcbc_top DUT (.*);
    always #5 pclk = ~pclk;
    task automatic final_report();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] s);
        int k;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd; pstrb <= s;
        @(posedge pclk) penable <= 1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_errors++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [31:0] wd, input logic [3:0] s);
        logic [31:0] lm;
        lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & UPCBC_WR_MASK;
        apb(1, 12'h000, wd, s);
        m = (m & ~lm) | (wd & lm);
    endtask
    task automatic rdchk();
        upcbc_ctrl_t ec;
        ec = {m[31], m[24], m[23], m[19], m[17], m[16] & m[15], m[15], m[14], m[9], m[0]};
        apb(0, 12'h000, 32'h0, 4'h0);
        `CHK(rd, m | {13'h0, core_supply_ready_raw & ~hv_por_active, 5'h0,
            pll_locked & m[16] & m[15], 12'h0})
        `CHK(ctrl, ec)
        `CHK(common_clk_en, ~m[31] | m[0])
        `CHK(common_test_mode, m[24])
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, usb_bus_reset, lite_reset} = '0;
        {high_speed, core_supply_ready_raw, hv_por_active, pll_locked} = 4'hd;
        image = 5'b11000;
        presetn = 0;
        void'($urandom(32'h8772cf4b));
        repeat (16) @(posedge pclk);
        presetn <= 1;
        m = 32'h0003_0000;
        repeat (5) @(posedge pclk);
        rdchk();
        $display("test reset values done");
        for (int i = 0; i < 12; i++) begin
            {hv_por_active, pll_locked, core_supply_ready_raw} <= 3'($urandom);
            d = $urandom;
            d[19] = 1'b0;
            wr(d, 4'($urandom));
            repeat (3) @(posedge pclk);
            rdchk();
        end
        $display("test random writes done");
        apb(0, 12'h004, 32'h0, 4'h0);
        `CHK(er, 1'b1)
        apb(0, 12'h0c4, 32'h0, 4'h0);
        `CHK(rd, 32'h0)
        rdchk();
        $display("test unmapped address done");
        for (int j = 0; j < 6; j++) begin
            high_speed <= j[0];
            image <= j < 4 ? 5'b11000 : (j == 4 ? 5'b00011 : 5'b00010);
            wr({14'h0, ~(j < 4 ? j[0] : j == 4), 17'h0}, 4'h4);
            if (j[1]) usb_bus_reset <= 1; else lite_reset <= 1;
            repeat (3) @(posedge pclk);
            {usb_bus_reset, lite_reset} <= 2'b00;
            repeat (4) @(posedge pclk);
            m[17] = j < 4 ? j[0] : j == 4;
            rdchk();
        end
        $display("test fast start reload done");
        final_report();
    end
    initial begin
        #200000;
        n_errors++;
        final_report();
    end
endmodule

// file: test/upcbc_assertions.sv
// Checker with port assertions for the common block control register.
module upcbc_chk (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   hv_por_active,
    input wire logic                   pll_locked,
    input wire upcbc_pkg::upcbc_ctrl_t ctrl,
    input wire logic                   common_clk_en,
    input wire logic                   common_test_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    import upcbc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr0 = psel && !penable && pwrite && paddr == 12'h000;
    wire rd0 = pready && !pwrite && paddr == 12'h000;
    a_gate_off_clk: assert property (wr0 && pstrb[3] && pstrb[0] |-> ##2
        common_clk_en == (!$past(pwdata[31], 2) || $past(pwdata[0], 2))) else $error("clock gate");
    a_test_path: assert property (wr0 && pstrb[3] |-> ##2
        common_test_mode == $past(pwdata[24], 2)) else $error("test path select");
    a_xtal_ref_fast: assert property (wr0 && pstrb[2] |-> ##2 (ctrl[7:5] ==
        {$past(pwdata[23], 2), $past(pwdata[19], 2), $past(pwdata[17], 2)})) else $error("byte two");
    a_pll_enable: assert property (ctrl.usb_pll_enable |-> ctrl.common_power_down_n)
        else $error("pll enabled while common power down");
    a_power_down_n: assert property (wr0 && pstrb[1] |-> ##2 (ctrl[3:1] ==
        {$past(pwdata[15], 2), $past(pwdata[14], 2), $past(pwdata[9], 2)})) else $error("byte one");
    a_bad_addr: assert property (psel && !penable && paddr != 12'h000 |=>
        pready && pslverr && prdata == 32'h0) else $error("unmapped access");
    a_rsvd_zero: assert property (pready && !pwrite |->
        (prdata & ~(UPCBC_WR_MASK | 32'h0004_1000)) == 32'h0) else $error("reserved bits");
    a_core_gated: assert property (hv_por_active [*6] ##0 rd0 |-> !prdata[18])
        else $error("core ready not gated");
    a_not_usable: assert property ((!pll_locked) [*6] ##0 rd0 |-> !prdata[12])
        else $error("clocks usable without lock");
    c_write: cover property (wr0 && pstrb == 4'hf);
    c_error: cover property (pready && pslverr);
    c_read: cover property (rd0 && prdata[18]);
endmodule
bind upcbc_top upcbc_chk u_chk (.*);
